// *** core/aiim_mapper.sv ***
// What this block does
// - one-channel module: main value to word 0, reference value to word 1
// - two-channel module: channel 1 to word 0, channel 2 to word 1
// - four-channel module: channels 1 to 4 in words 0 to 3
// - HART module image layout chosen by its configured operating mode
// - HART plain mode: one whole 16-bit word per channel
// - HART mailbox mode: 12-byte input and 12-byte output image
// - mailbox mode: control or status byte, dummy, mailbox fill first eight bytes
// - mailbox mode: channel 1 and 2 values in input words 4 and 5
// - mailbox input: status low byte of word 0, response in words 1-3
// - values stored little-endian: low data byte in low byte of word
// - all analog words come before digital input data
//
// aiim_mapper: scans module slots each cycle of an update and writes the
// input process image word by word; output image words are split back out.
// assumes: slot config static during a scan, inputs on the sys_clk domain.
`timescale 1ns/1ps
module aiim_mapper import aiim_pkg::*; #(
  parameter int SLOTS = AIIM_SLOT_W,
  parameter int DEPTH = AIIM_IMG_W,
  parameter int AW = AIIM_ADDR_W,
  parameter int DI_WORDS = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scan_start,
  input wire logic [2*SLOTS-1:0] slot_kind,
  input wire logic [2*SLOTS-1:0] slot_sub,
  input wire logic [SLOTS*4*AIIM_BYTE_W*2-1:0] slot_data_bytes,
  input wire logic [SLOTS*AIIM_BYTE_W-1:0] module_status_byte,
  input wire logic [SLOTS*3*AIIM_WORD_W-1:0] mailbox_response_word,
  input wire logic [DI_WORDS*AIIM_WORD_W-1:0] digital_in_words,
  input wire logic [AW-1:0] img_rd_addr,
  output logic [AIIM_WORD_W-1:0] img_rd_data,
  output logic scan_busy,
  output logic scan_done,
  output logic [AW-1:0] img_len,
  input wire logic [AIIM_WORD_W-1:0] out_img_word,
  input wire logic [AW-1:0] out_img_addr,
  input wire logic out_img_wr,
  input wire logic [AW-1:0] hart_out_base,
  output logic [AIIM_BYTE_W-1:0] module_control_byte,
  output logic [3*AIIM_WORD_W-1:0] mailbox_request_word
);
  aiim_state_t state_ff;
  logic [$clog2(SLOTS+1)-1:0] slot_ff;
  logic [3:0] word_ff;
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] img_len_ff;
  logic busy_ff;
  logic done_ff;
  logic wr_en;
  logic [AIIM_WORD_W-1:0] wr_word;
  logic [3:0] slot_words;
  aiim_kind_t kind;
  aiim_sub_t sub;
  logic [$clog2(SLOTS)-1:0] sidx;
  logic [AIIM_BYTE_W-1:0] ctl_ff;
  logic [3*AIIM_WORD_W-1:0] req_ff;
  localparam logic [3:0] QUAD_WORDS = 4'h4;
  localparam int SLOT_BYTES = 8;

  assign sidx = slot_ff[$clog2(SLOTS)-1:0];
  assign kind = aiim_kind_t'(slot_kind[2*sidx +: 2]);
  assign sub = aiim_sub_t'(slot_sub[2*sidx +: 2]);

  // measured value n of this slot, little-endian byte pair
  function automatic logic [AIIM_WORD_W-1:0] meas(input logic [1:0] ch);
    logic [AIIM_BYTE_W-1:0] lo;
    logic [AIIM_BYTE_W-1:0] hi;
    lo = slot_data_bytes[(sidx*8 + 2*ch)*AIIM_BYTE_W +: AIIM_BYTE_W];
    hi = slot_data_bytes[(sidx*8 + 2*ch + 1)*AIIM_BYTE_W +: AIIM_BYTE_W];
    meas = {hi, lo};
  endfunction

  always_comb begin
    slot_words = 4'h0;
    case (kind)
      AIIM_KIND_1CH: slot_words = AIIM_WORDS_PLAIN;
      AIIM_KIND_2CH: slot_words = (sub == AIIM_K2_HART_MBX) ? AIIM_WORDS_MBX
                                                            : AIIM_WORDS_PLAIN;
      AIIM_KIND_4CH: slot_words = QUAD_WORDS;
      default: slot_words = 4'h0;
    endcase
  end

  always_comb begin
    wr_word = AIIM_ZERO_WORD;
    if (state_ff == AIIM_ST_DIGI) begin
      wr_word = digital_in_words[word_ff*AIIM_WORD_W +: AIIM_WORD_W];
    end else if (kind == AIIM_KIND_2CH && sub == AIIM_K2_HART_MBX) begin
      if (word_ff == AIIM_W_STATUS) begin
        wr_word = {AIIM_RSVD_HI, module_status_byte[sidx*AIIM_BYTE_W +: AIIM_BYTE_W]};
      end else if (word_ff <= AIIM_W_MBX_LAST) begin
        wr_word = mailbox_response_word[(sidx*3 + word_ff - AIIM_W_MBX_FIRST)*AIIM_WORD_W
                  +: AIIM_WORD_W];
      end else if (word_ff == AIIM_W_CH1_MBX) begin
        wr_word = meas(2'h0);
      end else begin
        wr_word = meas(2'h1);
      end
    end else begin
      wr_word = meas(word_ff[1:0]);
    end
  end

  assign wr_en = (state_ff == AIIM_ST_SLOT && word_ff < slot_words)
              || state_ff == AIIM_ST_DIGI;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= AIIM_ST_IDLE;
      slot_ff <= '0;
      word_ff <= 4'h0;
      wptr_ff <= '0;
    end else begin
      case (state_ff)
        AIIM_ST_IDLE: begin
          if (scan_start) begin
            state_ff <= AIIM_ST_SLOT;
            slot_ff <= '0;
            word_ff <= 4'h0;
            wptr_ff <= '0;
          end
        end
        AIIM_ST_SLOT: begin
          if (wr_en) begin
            wptr_ff <= wptr_ff + AW'(1);
          end
          if (word_ff + 4'h1 >= slot_words) begin
            word_ff <= 4'h0;
            if (slot_ff == SLOTS - 1) begin
              state_ff <= AIIM_ST_DIGI; // digital follows analog
            end else begin
              slot_ff <= slot_ff + 1'b1;
            end
          end else begin
            word_ff <= word_ff + 4'h1;
          end
        end
        AIIM_ST_DIGI: begin
          wptr_ff <= wptr_ff + AW'(1);
          if (word_ff == 4'(DI_WORDS - 1)) begin
            state_ff <= AIIM_ST_DONE;
          end else begin
            word_ff <= word_ff + 4'h1;
          end
        end
        AIIM_ST_DONE: state_ff <= AIIM_ST_IDLE;
        default: state_ff <= AIIM_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      img_len_ff <= '0;
    end else begin
      busy_ff <= (state_ff != AIIM_ST_IDLE && state_ff != AIIM_ST_DONE)
              || (state_ff == AIIM_ST_IDLE && scan_start);
      done_ff <= state_ff == AIIM_ST_DONE;
      if (state_ff == AIIM_ST_DONE) begin
        img_len_ff <= wptr_ff;
      end
    end
  end

  // output image words of the HART slot; controller owns their content
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl_ff <= '0;
      req_ff <= '0;
    end else if (out_img_wr) begin
      if (out_img_addr == hart_out_base) begin
        ctl_ff <= out_img_word[AIIM_BYTE_W-1:0]; // high byte ignored
      end else if (out_img_addr > hart_out_base
                   && out_img_addr <= hart_out_base + AW'(AIIM_W_MBX_LAST)) begin
        req_ff[(out_img_addr - hart_out_base - AW'(1))*AIIM_WORD_W +: AIIM_WORD_W]
          <= out_img_word; // words 4 and 5 unused
      end
    end
  end

  assign scan_busy = busy_ff;
  assign scan_done = done_ff;
  assign img_len = img_len_ff;
  assign module_control_byte = ctl_ff;
  assign mailbox_request_word = req_ff;

  aiim_image_ram #(.WIDTH(AIIM_WORD_W), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .sys_clk(sys_clk),
    .wr_en(wr_en),
    .wr_addr(wptr_ff),
    .wr_data(wr_word),
    .rd_addr(img_rd_addr),
    .rd_data(img_rd_data)
  );

  // counts the words really walked, so a wrong slot size cannot hide
  mbx_slot_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == AIIM_ST_SLOT && kind == AIIM_KIND_2CH && sub == AIIM_K2_HART_MBX
     && word_ff == AIIM_W_MBX_FIRST) |-> ##4 (word_ff == AIIM_W_CH2_MBX && wr_en)
     ##1 word_ff == AIIM_W_STATUS)
    else $error("mailbox slot not six words");
  status_hi_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_en && state_ff == AIIM_ST_SLOT && sub == AIIM_K2_HART_MBX && kind == AIIM_KIND_2CH
     && word_ff == AIIM_W_STATUS) |-> wr_word[15:8] == AIIM_RSVD_HI)
    else $error("status word high byte not reserved");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    scan_done |=> !scan_done) else $error("done longer than one cycle");
  busy_end_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == AIIM_ST_DIGI) |-> ##[1:70] scan_done)
    else $error("scan did not finish");
  ctl_take_a: assert property (@(posedge sys_clk) disable iff (reset)
    (out_img_wr && out_img_addr == hart_out_base)
    |=> {8'h00, ctl_ff} == ($past(out_img_word) & 16'h00FF))
    else $error("control byte not taken");
  le_order_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == AIIM_ST_SLOT && kind == AIIM_KIND_4CH && word_ff == 4'h0)
    |-> wr_word[AIIM_BYTE_W-1:0]
        == slot_data_bytes[sidx*SLOT_BYTES*AIIM_BYTE_W +: AIIM_BYTE_W])
    else $error("low data byte not in low byte");
  plain_two_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == AIIM_ST_SLOT && kind == AIIM_KIND_2CH && sub != AIIM_K2_HART_MBX
     && word_ff == AIIM_W_CH1) |-> wr_en ##1 (word_ff == AIIM_W_CH2 && wr_en)
     ##1 word_ff == AIIM_W_CH1)
    else $error("plain two-channel slot size");
  ch1_word_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_ff == AIIM_ST_SLOT && kind == AIIM_KIND_2CH && sub == AIIM_K2_HART_MBX
     && word_ff == AIIM_W_CH1_MBX)
    |-> wr_word == {slot_data_bytes[(sidx*SLOT_BYTES + 1)*AIIM_BYTE_W +: AIIM_BYTE_W],
                    slot_data_bytes[sidx*SLOT_BYTES*AIIM_BYTE_W +: AIIM_BYTE_W]})
    else $error("channel 1 not in word 4");
endmodule

// *** core/aiim_pkg.sv ***
// aiim_pkg: constants shared by the analog input image mapper
// assumes: one 100 MHz clock, word-organised process image
package aiim_pkg;
  localparam int AIIM_WORD_W = 16;
  localparam int AIIM_BYTE_W = 8;
  localparam int AIIM_IMG_W = 64;
  localparam int AIIM_SLOT_W = 4;
  localparam int AIIM_ADDR_W = 6;
  localparam logic [3:0] AIIM_WORDS_MBX = 4'h6;
  localparam logic [3:0] AIIM_WORDS_PLAIN = 4'h2;
  localparam logic [3:0] AIIM_W_STATUS = 4'h0;
  localparam logic [3:0] AIIM_W_MBX_FIRST = 4'h1;
  localparam logic [3:0] AIIM_W_MBX_LAST = 4'h3;
  localparam logic [3:0] AIIM_W_CH1_MBX = 4'h4;
  localparam logic [3:0] AIIM_W_CH2_MBX = 4'h5;
  localparam logic [3:0] AIIM_W_CH1 = 4'h0;
  localparam logic [3:0] AIIM_W_CH2 = 4'h1;
  localparam logic [7:0] AIIM_RSVD_HI = 8'h00;
  localparam logic [15:0] AIIM_ZERO_WORD = 16'h0000;
  typedef enum logic [1:0] {AIIM_KIND_NONE, AIIM_KIND_1CH, AIIM_KIND_2CH,
    AIIM_KIND_4CH} aiim_kind_t;
  typedef enum logic [1:0] {AIIM_K2_PLAIN, AIIM_K2_HART_PLAIN, AIIM_K2_HART_MBX,
    AIIM_K2_RSVD} aiim_sub_t;
  typedef enum {AIIM_ST_IDLE, AIIM_ST_SLOT, AIIM_ST_DIGI, AIIM_ST_DONE} aiim_state_t;
endpackage

// *** core/aiim_image_ram.sv ***
// aiim_image_ram: word memory holding the input process image
// assumes: single clock, one write and one registered read port
`timescale 1ns/1ps
module aiim_image_ram import aiim_pkg::*; #(
  parameter int WIDTH = AIIM_WORD_W,
  parameter int DEPTH = AIIM_IMG_W,
  parameter int AW = AIIM_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// *** test/aiim_ctrl_model.sv ***
// aiim_ctrl_model: controller side, sweeps the input image, writes output words
// assumes: registered image read, one bench request at a time
`timescale 1ns/1ps
module aiim_ctrl_model import aiim_pkg::*; #(
  parameter int AW = AIIM_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic rd_go,
  input wire logic [AW-1:0] rd_count,
  input wire logic [AIIM_WORD_W-1:0] img_rd_data,
  output logic [AW-1:0] img_rd_addr,
  output logic rd_valid,
  output logic rd_busy,
  output logic [AIIM_WORD_W-1:0] rd_word,
  input wire logic wr_go,
  input wire logic [2:0] wr_off,
  input wire logic [AIIM_WORD_W-1:0] wr_val,
  input wire logic [AW-1:0] hart_out_base,
  output logic [AIIM_WORD_W-1:0] out_img_word,
  output logic [AW-1:0] out_img_addr,
  output logic out_img_wr
);
  initial begin
    {img_rd_addr, rd_valid, rd_busy, rd_word} = '0;
    {out_img_word, out_img_addr, out_img_wr} = '0;
    forever begin
      @(posedge sys_clk);
      if (rd_go) begin
        rd_busy <= 1'b1;
        // two cycles a word: simple, slow reader
        for (int i = 0; i < rd_count; i++) begin
          img_rd_addr <= AW'(i);
          @(posedge sys_clk);
          rd_valid <= 1'b0;
          @(posedge sys_clk);
          rd_word <= img_rd_data;
          rd_valid <= 1'b1;
        end
        @(posedge sys_clk);
        rd_valid <= 1'b0;
        rd_busy <= 1'b0;
      end else if (wr_go) begin
        out_img_addr <= hart_out_base + AW'(wr_off);
        out_img_word <= wr_val;
        out_img_wr <= 1'b1;
        @(posedge sys_clk);
        out_img_wr <= 1'b0;
        // released word must not keep its last value
        out_img_word <= ~wr_val;
      end
    end
  end
endmodule

// *** test/aiim_mapper_tb.sv ***
// aiim_mapper_tb: self-checking bench for the analog input image mapper
// assumes: controller model aiim_ctrl_model, design at package defaults
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module aiim_mapper_tb import aiim_pkg::*;;
  localparam int SL = 4;
  localparam int DW = 2;
  localparam int AW = 6;
  logic sys_clk = 1'b0, reset = 1'b1, scan_start = 1'b0, rd_go = 1'b0, wr_go = 1'b0;
  logic [2*SL-1:0] slot_kind = '0, slot_sub = '0;
  logic [SL*64-1:0] sdat = '0;
  logic [SL*8-1:0] stat = '0;
  logic [SL*48-1:0] resp = '0;
  logic [DW*16-1:0] diw = '0;
  logic [AW-1:0] hbase = '0, rd_count = '0, rd_addr, len, oa;
  logic [15:0] wv = '0, rd_data, rd_word, ow, ew;
  logic [15:0] exp_q[$];
  logic [7:0] ctl, ectl;
  logic [47:0] req, ereq;
  logic [2:0] wr_off = '0;
  logic busy, done, owr, rd_valid, rd_busy;
  int n_fail = 0, checks = 0, cyc = 0, seed = 85;
  aiim_mapper #(.SLOTS(SL), .DI_WORDS(DW)) dut (.sys_clk(sys_clk), .reset(reset),
    .scan_start(scan_start), .slot_kind(slot_kind), .slot_sub(slot_sub),
    .slot_data_bytes(sdat), .module_status_byte(stat), .mailbox_response_word(resp),
    .digital_in_words(diw), .img_rd_addr(rd_addr), .img_rd_data(rd_data),
    .scan_busy(busy), .scan_done(done), .img_len(len), .out_img_word(ow),
    .out_img_addr(oa), .out_img_wr(owr), .hart_out_base(hbase),
    .module_control_byte(ctl), .mailbox_request_word(req));
  aiim_ctrl_model #(.AW(AW)) ctrl (.sys_clk(sys_clk), .rd_go(rd_go), .rd_count(rd_count),
    .img_rd_data(rd_data), .img_rd_addr(rd_addr), .rd_valid(rd_valid), .rd_busy(rd_busy),
    .rd_word(rd_word), .wr_go(wr_go), .wr_off(wr_off), .wr_val(wv),
    .hart_out_base(hbase), .out_img_word(ow), .out_img_addr(oa), .out_img_wr(owr));
  always #5 sys_clk = ~sys_clk;
  task automatic close_out;
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run_scan(input bit twice);
    int n, k, nw;
    n = 0;
    for (int s = 0; s < SL; s++) begin
      k = slot_kind[2*s+:2];
      if (k == 2 && slot_sub[2*s+:2] == 2'h2) begin
        exp_q.push_back({AIIM_RSVD_HI, stat[8*s+:8]});
        for (int w = 0; w < 3; w++) exp_q.push_back(resp[48*s+16*w+:16]);
        for (int w = 0; w < 2; w++) exp_q.push_back(sdat[64*s+16*w+:16]);
        n += 6;
      end else begin
        nw = k == 3 ? 4 : (k == 0 ? 0 : 2);
        for (int w = 0; w < nw; w++) exp_q.push_back(sdat[64*s+16*w+:16]);
        n += nw;
      end
    end
    for (int w = 0; w < DW; w++) exp_q.push_back(diw[16*w+:16]);
    n += DW;
    @(negedge sys_clk);
    scan_start = 1'b1;
    @(negedge sys_clk);
    scan_start = 1'b0;
    `CHK("scan busy", 1'b1, busy)
    if (twice) begin
      @(negedge sys_clk);
      scan_start = 1'b1;
      @(negedge sys_clk);
      scan_start = 1'b0;
    end
    @(posedge sys_clk iff done === 1'b1);
    @(negedge sys_clk);
    `CHK("image length", AW'(n), len)
    `CHK("scan idle", 1'b0, busy)
    `CHK("done pulse", 1'b0, done)
    rd_count = AW'(n);
    rd_go = 1'b1;
    @(negedge sys_clk);
    rd_go = 1'b0;
    while (rd_busy === 1'b1) @(negedge sys_clk);
    `CHK("words left", 0, exp_q.size())
  endtask
  // watcher: oldest note against each word the controller reads
  always @(posedge sys_clk) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      ew = exp_q.size() > 0 ? exp_q.pop_front() : ~rd_word;
      `CHK("image word", ew, rd_word)
    end
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    for (int t = 0; t < 10; t++) begin
      @(negedge sys_clk);
      slot_kind = t == 0 ? 8'hB9 : 8'($random(seed));
      slot_sub = t == 0 ? 8'hC8 : 8'($random(seed));
      // sub field only means something for two-channel slots
      for (int s = 0; s < SL; s++) if (slot_kind[2*s+:2] != 2'h2) slot_sub[2*s+:2] = 2'h0;
      for (int i = 0; i < 8; i++) sdat[32*i+:32] = $random(seed);
      for (int i = 0; i < 6; i++) resp[32*i+:32] = $random(seed);
      stat = $random(seed);
      diw = $random(seed);
      run_scan(t == 1);
    end
    hbase = {1'b0, 5'($random(seed))};
    ectl = '0;
    ereq = '0;
    // words 5 and 4 first: must leave the reset values alone
    for (int w = 5; w >= 0; w--) begin
      wr_off = 3'(w);
      wv = 16'($random(seed));
      wr_go = 1'b1;
      @(negedge sys_clk);
      wr_go = 1'b0;
      repeat (3) @(negedge sys_clk);
      if (w == 0) ectl = wv[7:0];
      else if (w < 4) ereq[16*(w-1)+:16] = wv;
      `CHK("control byte", ectl, ctl)
      `CHK("request words", ereq, req)
    end
    close_out;
  end
endmodule
